// *** core/srd_pkg.sv ***
package srd_pkg;

    // ------------------------------------------------------------
    // request stream lengths and field positions
    // ------------------------------------------------------------
    localparam logic [4:0] SRD_LEN_CABLE = 5'h07;
    localparam logic [4:0] SRD_LEN_BACKPLANE = 5'h0b;
    localparam logic [4:0] SRD_LEN_READ = 5'h09;
    localparam logic [4:0] SRD_LEN_WRITE = 5'h11;
    localparam logic [4:0] SRD_POS_FIRST = 5'h01;
    localparam logic [4:0] SRD_POS_TYPE_LO = 5'h03;
    localparam logic [4:0] SRD_POS_NONE = 5'h1f;

    // ------------------------------------------------------------
    // request type codes, bit 1 is the high bit
    // ------------------------------------------------------------
    localparam logic [2:0] SRD_TYPE_IMMEDIATE = 3'h0;
    localparam logic [2:0] SRD_TYPE_FAIR = 3'h3;
    localparam logic [2:0] SRD_TYPE_READ = 3'h4;
    localparam logic [2:0] SRD_TYPE_WRITE = 3'h5;
    localparam logic [1:0] SRD_BASE_SPEED_CODE = 2'h0;
    localparam logic [3:0] SRD_PRIO_FAIR = 4'h0;

    // ------------------------------------------------------------
    // software port map and reset values
    // ------------------------------------------------------------
    localparam int SRD_NUM_REGS = 16;
    localparam logic [4:0] SRD_SW_CTRL = 5'h10;
    localparam logic [4:0] SRD_SW_STAT = 5'h11;
    localparam logic [4:0] SRD_SW_ERR = 5'h12;
    localparam logic [3:0] SRD_PRIO_REG_IDX = 4'h1;
    localparam logic [7:0] SRD_REG_RST = 8'h00;
    localparam logic [1:0] SRD_CTRL_RST = 2'h2;
    localparam int SRD_CTRL_BACKPLANE = 0;
    localparam int SRD_CTRL_ENABLE = 1;

    typedef enum logic [1:0] {
        SRD_ARB_IMMEDIATE = 2'b00,
        SRD_ARB_FAIR = 2'b01,
        SRD_ARB_URGENT = 2'b10
    } srd_arb_e;

    typedef enum logic [0:0] {
        SRD_ST_IDLE = 1'b0,
        SRD_ST_RECV = 1'b1
    } srd_state_e;

    typedef struct packed {
        srd_arb_e arb;
        logic [1:0] speed;
        logic [3:0] prio;
        logic backplane;
    } srd_bus_req_s;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] data;
    } srd_status_s;

endpackage : srd_pkg

// *** core/srd_decoder.sv ***
`timescale 1ns/10ps
// Summary of operation
// RULE1: seven-bit cable bus request decoded
// RULE2: eleven-bit backplane bus request with priority
// RULE3: nine-bit stream decoded as register read
// RULE4: seventeen-bit stream decoded as register write
// RULE5: every stream opens with start bit one
// RULE6: every stream closes with stop bit zero
// RULE7: bits one to three classify, set length
// RULE8: cable bits four, five give speed
// RULE9: backplane speed bits ignored, sent zero
// RULE10: backplane bits six to nine give priority
// RULE11: all-ones backplane priority never sent
// RULE12: cable request takes internal priority register
// RULE13: read carries type 100, address bits 4-7
// RULE14: write carries 101, address, data bits 8-15
// RULE15: immediate type seizes bus without arbitration
// RULE16: fair type arbitrates after subaction gap
// RULE17: read returns register through status transfer
// RULE18: one request bit sampled per clock
// RULE19: bit zero first, ascending order
// RULE20: request line idles low between streams
// RULE21: line sampled on rising interface clock
// RULE22: write data loaded when stop bit arrives
// RULE23: reserved type codes are discarded
module srd_decoder
    import srd_pkg::*;
(
    input wire logic clk_sys, // interface clock
    input wire logic sys_rst, // synchronous reset, high
    input wire logic link_request_line, // serial request from link
    input wire logic arb_won, // pending bus request won
    input wire logic arb_lost, // pending bus request lost
    input wire logic status_done, // status transfer completed
    input wire logic [4:0] sw_addr, // software address
    input wire logic [7:0] sw_wdata, // software write data
    input wire logic sw_wr, // software write strobe
    input wire logic sw_rd, // software read strobe
    output logic [7:0] sw_rdata, // read data, cycle after strobe
    output logic bus_req_pending, // bus request held for arbiter
    output srd_bus_req_s bus_req, // fields of pending request
    output logic status_req, // status transfer wanted
    output srd_status_s status_word // register address and contents
);

    // ------------------------------------------------------------
    // line synchroniser
    // ------------------------------------------------------------
    logic line_s1_q;
    logic line_s2_q;
    // two stages: the line is launched by the link's own flops

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            line_s1_q <= 1'b0;
            line_s2_q <= 1'b0;
        end else begin
            line_s1_q <= link_request_line; // RULE21
            line_s2_q <= line_s1_q;
        end
    end

    // ------------------------------------------------------------
    // control and register storage declarations
    // ------------------------------------------------------------
    logic [1:0] ctrl_q;
    logic [7:0] regs_q [SRD_NUM_REGS];
    logic [7:0] err_cnt_q;
    logic ignored_q;

    // ------------------------------------------------------------
    // stream receiver
    // ------------------------------------------------------------
    srd_state_e state_q;
    logic [4:0] pos_q;
    logic [4:0] last_q;
    logic [14:0] sr_q;
    logic [2:0] type_q;
    logic bp_q;
    logic [2:0] tcode;
    logic fin;
    logic stop_ok;
    logic start;
    logic at_type;

    assign tcode = {sr_q[1:0], line_s2_q};
    assign fin = (state_q == SRD_ST_RECV) && (pos_q == last_q);
    assign stop_ok = fin && !line_s2_q; // RULE6
    // a one seen while idle and enabled opens a stream; the line idles low
    assign start = (state_q == SRD_ST_IDLE) && line_s2_q
                   && ctrl_q[SRD_CTRL_ENABLE]; // RULE5
    assign at_type = (state_q == SRD_ST_RECV)
                     && (pos_q == SRD_POS_TYPE_LO);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= SRD_ST_IDLE;
        end else begin
            case (state_q)
                SRD_ST_IDLE: begin
                    if (start) begin
                        state_q <= SRD_ST_RECV;
                    end
                end
                SRD_ST_RECV: begin
                    if (fin) begin
                        state_q <= SRD_ST_IDLE;
                    end
                end
                default: begin
                    state_q <= SRD_ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // bit counter and shift register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pos_q <= SRD_POS_FIRST;
        end else if (start) begin
            pos_q <= SRD_POS_FIRST;
        end else if ((state_q == SRD_ST_RECV) && !fin) begin
            pos_q <= pos_q + 5'h01; // RULE18
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sr_q <= 15'h0000;
        end else if (start) begin
            sr_q <= 15'h0000;
        end else if ((state_q == SRD_ST_RECV) && !fin) begin
            sr_q <= {sr_q[13:0], line_s2_q}; // RULE18 RULE19
        end
    end

    // ------------------------------------------------------------
    // type capture
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            type_q <= SRD_TYPE_IMMEDIATE;
            bp_q <= 1'b0;
        end else if (at_type) begin // RULE7
            type_q <= tcode;
            bp_q <= ctrl_q[SRD_CTRL_BACKPLANE];
        end
    end

    // ------------------------------------------------------------
    // stream length from type code and bus format
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            last_q <= SRD_POS_NONE;
        end else if (start) begin
            last_q <= SRD_POS_NONE;
        end else if (at_type) begin // RULE7
            case (tcode)
                SRD_TYPE_IMMEDIATE, SRD_TYPE_FAIR: begin
                    if (ctrl_q[SRD_CTRL_BACKPLANE]) begin
                        last_q <= SRD_LEN_BACKPLANE - 5'h01; // RULE2
                    end else begin
                        last_q <= SRD_LEN_CABLE - 5'h01; // RULE1
                    end
                end
                SRD_TYPE_READ: begin
                    last_q <= SRD_LEN_READ - 5'h01; // RULE3
                end
                SRD_TYPE_WRITE: begin
                    last_q <= SRD_LEN_WRITE - 5'h01; // RULE4
                end
                default: begin
                    // reserved: swallow a cable-length stream
                    last_q <= SRD_LEN_CABLE - 5'h01; // RULE23
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // decoded actions
    // ------------------------------------------------------------
    logic is_bus;
    logic do_bus;
    logic do_read;
    logic do_write;
    logic [3:0] rd_addr;
    logic [3:0] wr_addr;
    logic [7:0] wr_data;
    logic [3:0] bp_prio;

    assign is_bus = stop_ok && ((type_q == SRD_TYPE_IMMEDIATE)
                    || (type_q == SRD_TYPE_FAIR)); // RULE23
    assign do_bus = is_bus && (!bus_req_pending || arb_won || arb_lost);
    assign do_read = stop_ok && (type_q == SRD_TYPE_READ); // RULE13
    assign do_write = stop_ok && (type_q == SRD_TYPE_WRITE); // RULE14
    // fields sit right-aligned in sr_q once the stop bit is seen
    assign rd_addr = sr_q[3:0]; // RULE13
    assign wr_addr = sr_q[11:8]; // RULE14
    assign wr_data = sr_q[7:0]; // RULE14
    assign bp_prio = sr_q[3:0]; // RULE10

    // ------------------------------------------------------------
    // bus request hand-off to the arbiter
    // ------------------------------------------------------------
    logic pend_q;
    srd_bus_req_s req_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pend_q <= 1'b0;
            req_q <= '{SRD_ARB_IMMEDIATE, 2'h0, 4'h0, 1'b0};
        end else begin
            // a new request in the clearing cycle wins
            if (do_bus) begin
                pend_q <= 1'b1;
                req_q.backplane <= bp_q;
                if (type_q == SRD_TYPE_IMMEDIATE) begin
                    req_q.arb <= SRD_ARB_IMMEDIATE; // RULE15
                end else if (bp_q && (bp_prio != SRD_PRIO_FAIR)) begin
                    req_q.arb <= SRD_ARB_URGENT; // RULE16
                end else begin
                    req_q.arb <= SRD_ARB_FAIR; // RULE16
                end
                if (bp_q) begin
                    req_q.speed <= SRD_BASE_SPEED_CODE; // RULE9
                    req_q.prio <= bp_prio; // RULE10
                end else begin
                    req_q.speed <= sr_q[1:0]; // RULE8
                    req_q.prio <= regs_q[SRD_PRIO_REG_IDX][3:0]; // RULE12
                end
            end else if (arb_won || arb_lost) begin
                pend_q <= 1'b0;
            end
        end
    end

    assign bus_req_pending = pend_q;
    assign bus_req = req_q;

    // ------------------------------------------------------------
    // register read answered by status transfer
    // ------------------------------------------------------------
    logic st_req_q;
    srd_status_s st_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_req_q <= 1'b0;
            st_q <= '{4'h0, 8'h00};
        end else begin
            if (do_read) begin
                st_req_q <= 1'b1; // RULE17
                st_q.addr <= rd_addr;
                st_q.data <= regs_q[rd_addr];
            end else if (status_done) begin
                st_req_q <= 1'b0;
            end
        end
    end

    assign status_req = st_req_q;
    assign status_word = st_q;

    // ------------------------------------------------------------
    // register file, link write beats software write
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < SRD_NUM_REGS; i++) begin
            if (sys_rst) begin
                regs_q[i] <= SRD_REG_RST;
            end else if (do_write && (wr_addr == i[3:0])) begin
                regs_q[i] <= wr_data; // RULE22
            end else if (sw_wr && (sw_addr == {1'b0, i[3:0]})) begin
                regs_q[i] <= sw_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // control, framing errors and ignored requests
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl_q <= SRD_CTRL_RST;
        end else if (sw_wr && (sw_addr == SRD_SW_CTRL)) begin
            ctrl_q <= sw_wdata[1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            err_cnt_q <= 8'h00;
        end else if (fin && line_s2_q && (err_cnt_q != 8'hff)) begin
            err_cnt_q <= err_cnt_q + 8'h01;
        end else if (sw_wr && (sw_addr == SRD_SW_ERR)) begin
            err_cnt_q <= 8'h00;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ignored_q <= 1'b0;
        end else if (is_bus && !do_bus) begin
            ignored_q <= 1'b1;
        end else if (sw_wr && (sw_addr == SRD_SW_STAT) && sw_wdata[0]) begin
            ignored_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // software read port
    // ------------------------------------------------------------
    logic [7:0] rdata_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else if (sw_rd) begin
            if (sw_addr < SRD_SW_CTRL) begin
                rdata_q <= regs_q[sw_addr[3:0]];
            end else if (sw_addr == SRD_SW_CTRL) begin
                rdata_q <= {6'h00, ctrl_q};
            end else if (sw_addr == SRD_SW_STAT) begin
                rdata_q <= {4'h0, state_q == SRD_ST_RECV, st_req_q,
                            pend_q, ignored_q};
            end else if (sw_addr == SRD_SW_ERR) begin
                rdata_q <= err_cnt_q;
            end else begin
                rdata_q <= 8'h00;
            end
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign sw_rdata = rdata_q;

endmodule : srd_decoder

// *** tb/srd_decoder_props.sv ***
`timescale 1ns/10ps
module srd_decoder_props
    import srd_pkg::*;
(
    input wire logic clk_sys, // clock
    input wire logic sys_rst, // reset
    input wire logic link_request_line, // serial line
    input wire logic arb_won, // won pulse
    input wire logic arb_lost, // lost pulse
    input wire logic status_done, // status done
    input wire logic [4:0] sw_addr, // address
    input wire logic [7:0] sw_wdata, // write data
    input wire logic sw_wr, // write strobe
    input wire logic sw_rd, // read strobe
    input wire logic [7:0] sw_rdata, // read data
    input wire logic bus_req_pending, // pending
    input wire srd_bus_req_s bus_req, // request fields
    input wire logic status_req, // status wanted
    input wire srd_status_s status_word // status word
);
    // ------------------------------------------------------------
    // cycles since the line was last high, no stream can be in flight
    // ------------------------------------------------------------
    logic [4:0] quiet_q;
    always_ff @(posedge clk_sys) begin
        if (sys_rst || link_request_line) begin
            quiet_q <= 5'h00;
        end else if (quiet_q != 5'h1f) begin
            quiet_q <= quiet_q + 5'h01;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_rdata_idle: assert property (!sw_rd |=> sw_rdata == 8'h00)
        else $error("read data not zero outside read cycle");
    a_unmapped_zero: assert property (sw_rd && sw_addr > SRD_SW_ERR
        |=> sw_rdata == 8'h00) else $error("unmapped read not zero");
    a_pend_stable: assert property (bus_req_pending && !arb_won &&
        !arb_lost |=> bus_req_pending && $stable(bus_req))
        else $error("pending request changed");
    a_pend_release: assert property ((arb_won || arb_lost) &&
        quiet_q > 5'h14 |=> !bus_req_pending)
        else $error("pending not cleared");
    a_stat_stable: assert property (
        status_req && !status_done && quiet_q > 5'h14
        |=> status_req && $stable(status_word))
        else $error("status request changed");
    a_stat_release: assert property (status_done && quiet_q > 5'h14
        |=> !status_req) else $error("status request not cleared");
    a_no_idle_req: assert property (
        quiet_q > 5'h14 && !bus_req_pending && !status_req
        |=> !bus_req_pending && !status_req)
        else $error("request without start bit");
    a_bp_speed: assert property (
        bus_req_pending && bus_req.backplane
        |-> bus_req.speed == SRD_BASE_SPEED_CODE)
        else $error("backplane speed not ignored");
    a_bp_fair: assert property (
        bus_req_pending && bus_req.backplane && bus_req.arb == SRD_ARB_FAIR
        |-> bus_req.prio == SRD_PRIO_FAIR) else $error("fair prio not zero");
    a_urgent_prio: assert property (
        bus_req_pending && bus_req.arb == SRD_ARB_URGENT
        |-> bus_req.backplane && bus_req.prio != SRD_PRIO_FAIR)
        else $error("urgent without backplane priority");
    c_status: cover property (status_req && status_done);
    c_urgent: cover property (bus_req_pending && bus_req.arb == SRD_ARB_URGENT);
    c_cable: cover property (bus_req_pending && !bus_req.backplane && arb_won);
endmodule : srd_decoder_props

// *** tb/srd_link_model.sv ***
`timescale 1ns/10ps
module srd_link_model (
    input wire logic clk_sys, // interface clock
    output logic link_request_line // serial request to device
);
    initial link_request_line = 1'b0;
    // v holds the bits between start and stop, right aligned
    task automatic send(input logic [4:0] len, input logic [16:0] v,
        input logic bad_stop);
        for (int i = 0; i < len; i++) begin
            @(posedge clk_sys);
            if (i == 0) begin
                link_request_line <= 1'b1;
            end else if (i == len - 1) begin
                link_request_line <= bad_stop;
            end else begin
                link_request_line <= v[len - 2 - i];
            end
        end
        if (bad_stop) begin
            @(posedge clk_sys);
            link_request_line <= 1'b0;
        end
    endtask : send
endmodule : srd_link_model

// *** tb/srd_decoder_tb.sv ***
`timescale 1ns/10ps
module srd_decoder_tb
    import srd_pkg::*;
;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic arb_won = 1'b0;
    logic arb_lost = 1'b0;
    logic status_done = 1'b0;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic [4:0] sw_addr = 5'h00;
    logic [7:0] sw_wdata = 8'h00;
    logic link_request_line, bus_req_pending, status_req;
    logic [7:0] sw_rdata;
    srd_bus_req_s bus_req;
    srd_status_s status_word;
    logic [7:0] rf [16] = '{default: 8'h00};
    int err_count = 0;
    int tests_run = 0;
    int seed = 84362;
    always #5 clk_sys = ~clk_sys;
    srd_link_model srd_link_model_i (.clk_sys(clk_sys),
        .link_request_line(link_request_line));
    srd_decoder srd_decoder_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .link_request_line(link_request_line), .arb_won(arb_won),
        .arb_lost(arb_lost), .status_done(status_done), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .bus_req_pending(bus_req_pending),
        .bus_req(bus_req), .status_req(status_req),
        .status_word(status_word));
    task automatic chk(input string nm, input logic [15:0] seen,
        input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wrap_up;
        if (err_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up
    task automatic sw_write(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sw_wr <= 1'b1;
        sw_addr <= a;
        sw_wdata <= d;
        @(posedge clk_sys);
        sw_wr <= 1'b0;
    endtask : sw_write
    task automatic sw_read(input logic [4:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        sw_rd <= 1'b1;
        sw_addr <= a;
        @(posedge clk_sys);
        sw_rd <= 1'b0;
        #1;
        d = sw_rdata;
    endtask : sw_read
    task automatic wait_flag(input logic which);
        for (int i = 0; i < 12; i++) begin
            @(posedge clk_sys);
            #1;
            if ((which ? status_req : bus_req_pending) === 1'b1) return;
        end
        err_count++;
        wrap_up();
    endtask : wait_flag
    // sel is {status_done, arb_lost, arb_won}
    task automatic free_flag(input logic [2:0] sel);
        repeat (24) @(posedge clk_sys);
        {status_done, arb_lost, arb_won} <= sel;
        @(posedge clk_sys);
        {status_done, arb_lost, arb_won} <= 3'h0;
        #1;
        chk("released", {bus_req_pending, status_req}, 16'h0);
    endtask : free_flag
    function automatic srd_bus_req_s exp_bus(logic [2:0] t, logic [1:0] s,
        logic [3:0] p, logic bp);
        exp_bus.backplane = bp;
        exp_bus.speed = bp ? SRD_BASE_SPEED_CODE : s;
        exp_bus.prio = bp ? p : rf[1][3:0];
        exp_bus.arb = (t == SRD_TYPE_IMMEDIATE) ? SRD_ARB_IMMEDIATE :
            (bp && p != SRD_PRIO_FAIR) ? SRD_ARB_URGENT : SRD_ARB_FAIR;
    endfunction : exp_bus
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        wrap_up();
    end
    initial begin : main
        logic [3:0] a, p;
        logic [7:0] d, rd;
        logic [2:0] t;
        logic [1:0] s;
        logic bp;
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        sw_read(SRD_SW_CTRL, rd);
        chk("ctrl", rd, 16'(SRD_CTRL_RST));
        sw_read(SRD_SW_ERR, rd);
        chk("errcnt", rd, 16'h0);
        sw_read(5'h1f, rd);
        chk("unmapped", rd, 16'h0);
        for (int n = 0; n < 12; n++) begin
            a = (n < 2) ? {4{~n[0]}} : 4'($random(seed));
            d = (n == 0) ? 8'hff : 8'($random(seed));
            srd_link_model_i.send(5'h11, {SRD_TYPE_WRITE, a, d}, 1'b0);
            rf[a] = d;
            srd_link_model_i.send(5'h09, {SRD_TYPE_READ, a}, 1'b0);
            wait_flag(1'b1);
            chk("status", status_word, {a, d});
            free_flag(3'h4);
            sw_read({1'b0, a}, rd);
            chk("regfile", rd, d);
        end
        rf[1] = 8'($random(seed));
        sw_write(5'h01, rf[1]);
        for (int n = 0; n < 8; n++) begin
            bp = n[2];
            t = n[0] ? SRD_TYPE_FAIR : SRD_TYPE_IMMEDIATE;
            s = 2'($random(seed));
            p = n[1] ? 4'h0 : 4'h1 + 4'({$random(seed)} % 14);
            if (n == 4) sw_write(SRD_SW_CTRL, 8'h03);
            if (bp) srd_link_model_i.send(5'h0b, {t, s, p}, 1'b0);
            else srd_link_model_i.send(5'h07, {t, s}, 1'b0);
            wait_flag(1'b0);
            chk("bus_req", bus_req, exp_bus(t, s, p, bp));
            chk("arb", bus_req.arb, exp_bus(t, s, p, bp).arb);
            free_flag(n[0] ? 3'h2 : 3'h1);
        end
        sw_write(SRD_SW_CTRL, 8'h02);
        t = SRD_TYPE_FAIR;
        s = 2'($random(seed));
        srd_link_model_i.send(5'h07, {t, s}, 1'b0);
        wait_flag(1'b0);
        srd_link_model_i.send(5'h07, {SRD_TYPE_IMMEDIATE, ~s}, 1'b0);
        repeat (24) @(posedge clk_sys);
        #1;
        chk("held", bus_req, exp_bus(t, s, 4'h0, 1'b0));
        sw_read(SRD_SW_STAT, rd);
        chk("stat", rd, 16'h03);
        sw_write(SRD_SW_STAT, 8'h01);
        sw_read(SRD_SW_STAT, rd);
        chk("stat_clr", rd, 16'h02);
        free_flag(3'h2);
        for (int n = 6; n < 8; n++) begin
            srd_link_model_i.send(5'h07, {3'(n), 2'h3}, 1'b0);
            repeat (24) @(posedge clk_sys);
            #1;
            chk("reserved", {bus_req_pending, status_req}, 16'h0);
        end
        sw_write(SRD_SW_CTRL, 8'h00);
        srd_link_model_i.send(5'h09, {SRD_TYPE_READ, 4'h2}, 1'b0);
        repeat (24) @(posedge clk_sys);
        #1;
        chk("disabled", status_req, 16'h0);
        sw_write(SRD_SW_CTRL, 8'h02);
        srd_link_model_i.send(5'h09, {SRD_TYPE_READ, 4'h2}, 1'b1);
        repeat (24) @(posedge clk_sys);
        #1;
        chk("bad_stop", status_req, 16'h0);
        sw_read(SRD_SW_ERR, rd);
        chk("errcnt", rd, 16'h1);
        sw_write(SRD_SW_ERR, 8'h00);
        sw_read(SRD_SW_ERR, rd);
        chk("errclr", rd, 16'h0);
        wrap_up();
    end
endmodule : srd_decoder_tb
bind srd_decoder srd_decoder_props srd_decoder_props_i (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .link_request_line(link_request_line),
    .arb_won(arb_won), .arb_lost(arb_lost), .status_done(status_done),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .bus_req_pending(bus_req_pending),
    .bus_req(bus_req), .status_req(status_req), .status_word(status_word));
